// File: core/bfb_builder.sv
// Beacon frame field builder with coordinator route cost tracking
// Function
// - Every beacon carries an empty guaranteed-time-slot list.
// - Pending short and extended address counts are both zero.
// - No pending address list is emitted.
// - Payload is exactly one octet: the coordinator route cost estimate.
// - Estimate comes from route costs computed by the routing layer.
// - Keep the lowest cost from coordinator-originated reply/request packets.
// - Communication failure with coordinator forces a non-coordinator's estimate to 0xFF.
// - Association loads the estimate with 0x7F unless a failure or the coordinator role wins that cycle.
// - A coordinator holds its estimate at 0x00.
// - No acknowledgement frame built; acks go to the PHY primitive.
// - Frame version subfield is reserved and carries no meaning here.
// - Superframe spec: orders, final slot, battery zero; association permit one.
// - GTS spec: descriptor count zero, permit zero.
`timescale 1ns/1ns
module bfb_builder
  import bfb_pkg::*;
(
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  // Node role and link events
  input  wire logic       i_is_coord,
  input  wire logic       i_assoc,
  input  wire logic       i_coord_fail,
  // Coordinator-originated route costs
  input  wire bfb_cost_t  i_path_reply_packet,
  input  wire bfb_cost_t  i_route_request_packet,
  input  wire bfb_cost_t  i_route_reply_packet,
  // Beacon request and acknowledgement request
  input  wire logic       i_beacon_req,
  input  wire logic       i_ack_req,
  // Byte stream to PHY
  output bfb_byte_t       o_tx_byte,
  output logic            o_tx_valid,
  input  wire logic       i_tx_ready,
  // Status
  output logic            o_busy,
  output logic [7:0]      o_coordinator_route_cost,
  output logic            o_phy_ack_send_primitive
);
  // ==========================================================
  // State
  typedef struct packed {
    bfb_state_t state;
    logic [2:0] idx;
    logic [7:0] cost;
    logic [7:0] snap;
    logic       busy;
    logic       ack;
  } bfb_regs_t;

  bfb_regs_t r_r;
  bfb_regs_t r_nxt;
  logic      wr_ready;
  logic      wr_valid;
  bfb_byte_t wr_byte;
  bfb_byte_t rd_byte;
  logic      rd_valid;
  logic [7:0] best;

  // ==========================================================
  // Beacon byte selection
  always_comb begin
    wr_byte = '0;
    case (r_r.idx)
      3'h0: wr_byte.data = {BFB_SLOT_ZERO, BFB_ORDER_ZERO};
      3'h1: wr_byte.data = {BFB_ASSOC_PERMIT, 1'b0, 1'b0, BFB_BATT_EXT,
                            BFB_SLOT_ZERO};
      3'h2: wr_byte.data = {BFB_GTS_PERMIT, 4'h0, BFB_CNT_ZERO};
      3'h3: wr_byte.data = {1'b0, BFB_CNT_ZERO, 1'b0, BFB_CNT_ZERO};
      default: begin
        wr_byte.data = r_r.snap;
        wr_byte.last = 1'b1;
      end
    endcase
  end
  assign wr_valid = (r_r.state == BFB_EMIT);

  // ==========================================================
  // Next-state logic
  always_comb begin
    r_nxt     = r_r;
    r_nxt.ack = i_ack_req;
    best      = r_r.cost;
    if (i_path_reply_packet.valid && i_path_reply_packet.cost < best) begin
      best = i_path_reply_packet.cost;
    end
    if (i_route_request_packet.valid && i_route_request_packet.cost < best) begin
      best = i_route_request_packet.cost;
    end
    if (i_route_reply_packet.valid && i_route_reply_packet.cost < best) begin
      best = i_route_reply_packet.cost;
    end
    if (i_is_coord) begin
      r_nxt.cost = BFB_COST_COORD;
    end else if (i_coord_fail) begin
      r_nxt.cost = BFB_COST_MAX;
    end else if (i_assoc) begin
      r_nxt.cost = BFB_COST_ASSOC;
    end else begin
      r_nxt.cost = best;
    end
    case (r_r.state)
      BFB_IDLE: begin
        if (i_beacon_req) begin
          r_nxt.state = BFB_EMIT;
          r_nxt.idx   = '0;
          r_nxt.snap  = r_r.cost;
          r_nxt.busy  = 1'b1;
        end
      end
      BFB_EMIT: begin
        if (wr_ready) begin
          if (r_r.idx == BFB_LAST_IDX) begin
            r_nxt.state = BFB_DONE;
          end else begin
            r_nxt.idx = r_r.idx + 3'h1;
          end
        end
      end
      BFB_DONE: begin
        r_nxt.state = BFB_IDLE;
        r_nxt.busy  = 1'b0;
      end
      default: r_nxt.state = BFB_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      r_r       <= '0;
      r_r.state <= BFB_IDLE;
      r_r.cost  <= BFB_COST_MAX;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ==========================================================
  // Output FIFO toward PHY
  bfb_fifo #(
    .WIDTH (BFB_FIFO_WIDTH),
    .DEPTH (BFB_FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk  (i_sys_clk),
    .i_rst      (i_rst),
    .i_wr_valid (wr_valid),
    .i_wr_data  (wr_byte),
    .o_wr_ready (wr_ready),
    .o_rd_valid (rd_valid),
    .o_rd_data  (rd_byte),
    .i_rd_ready (i_tx_ready)
  );

  // Only beacon body bytes leave here; frame control is built elsewhere
  assign o_tx_byte  = rd_byte;
  assign o_tx_valid = rd_valid;
  assign o_busy     = r_r.busy;
  assign o_coordinator_route_cost = r_r.cost;
  assign o_phy_ack_send_primitive = r_r.ack;

  // ==========================================================
  // Checks
  sequence s_fail;
    i_coord_fail && !i_is_coord;
  endsequence

  chk_coord_cost_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_is_coord |=> o_coordinator_route_cost == BFB_COST_COORD)
    else $error("coordinator cost not zero");
  chk_fail_cost_max: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_fail |=> o_coordinator_route_cost == BFB_COST_MAX)
    else $error("fail did not force max cost");
  chk_assoc_cost_init: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_assoc && !i_coord_fail && !i_is_coord) |=> o_coordinator_route_cost == BFB_COST_ASSOC)
    else $error("association did not load cost");
  chk_cost_keeps_min: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (!i_assoc && !i_coord_fail && !i_is_coord) |=>
      o_coordinator_route_cost <= $past(o_coordinator_route_cost))
    else $error("cost rose without cause");
  chk_payload_last: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (wr_valid && wr_byte.last) |-> (wr_byte.data == r_r.snap && r_r.idx == BFB_LAST_IDX))
    else $error("payload byte wrong");
  chk_pending_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (wr_valid && r_r.idx == 3'h3) |-> wr_byte.data == 8'h00)
    else $error("pending counts not zero");
  chk_gts_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (wr_valid && r_r.idx == 3'h2) |-> wr_byte.data == 8'h00)
    else $error("gts spec not zero");
  chk_superframe_bits: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (wr_valid && r_r.idx == 3'h1) |-> wr_byte.data == 8'h80)
    else $error("superframe high byte wrong");
  chk_ack_follows: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_ack_req |=> o_phy_ack_send_primitive)
    else $error("ack request not forwarded");
  chk_beacon_length: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (r_r.state == BFB_IDLE && i_beacon_req) |=> (r_r.state == BFB_EMIT)[*5])
    else $error("beacon shorter than five bytes");

  // Beacon step sequences
  sequence s_accept;
    r_r.state == BFB_IDLE && i_beacon_req;
  endsequence
  sequence s_emit_run;
    (r_r.state == BFB_EMIT && r_r.busy)[*5];
  endsequence

  chk_accept_busy: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_accept |=> s_emit_run ##1 o_busy)
    else $error("beacon accept did not run five emits");
  chk_snap_stable: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (r_r.state == BFB_EMIT) |=> $stable(r_r.snap))
    else $error("payload snapshot moved mid-beacon");
  chk_no_addr_list: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (wr_valid && r_r.idx == 3'h3 && wr_ready) |=> (wr_valid && wr_byte.last))
    else $error("byte after pending spec is not the payload");
  chk_gts_list_empty: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (wr_valid && r_r.idx == 3'h2 && wr_ready) |=> (wr_valid && r_r.idx == 3'h3))
    else $error("byte after gts spec is not the pending spec");
  chk_superframe_low: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (wr_valid && r_r.idx == 3'h0) |-> wr_byte.data == 8'h00)
    else $error("superframe low byte not zero");
  chk_ack_quiet: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_ack_req |=> !o_phy_ack_send_primitive)
    else $error("ack primitive without request");
  chk_done_release: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (r_r.state == BFB_DONE) |=> (r_r.state == BFB_IDLE && !o_busy))
    else $error("builder did not return to idle");
endmodule

// File: core/bfb_pkg.sv
// Package for the beacon frame field builder
package bfb_pkg;
  // ==========================================================
  // Beacon field constants
  localparam logic [7:0] BFB_COST_MAX      = 8'hFF;
  localparam logic [7:0] BFB_COST_ASSOC    = 8'h7F;
  localparam logic [7:0] BFB_COST_COORD    = 8'h00;
  localparam logic [3:0] BFB_ORDER_ZERO    = 4'h0;
  localparam logic [3:0] BFB_SLOT_ZERO     = 4'h0;
  localparam logic [2:0] BFB_CNT_ZERO      = 3'h0;
  localparam logic       BFB_ASSOC_PERMIT  = 1'b1;
  localparam logic       BFB_BATT_EXT      = 1'b0;
  localparam logic       BFB_GTS_PERMIT    = 1'b0;
  localparam logic [2:0] BFB_LAST_IDX      = 3'h4;
  localparam int         BFB_FIFO_DEPTH    = 16;
  localparam int         BFB_FIFO_WIDTH    = 9;

  // Builder states
  typedef enum logic [2:0] {
    BFB_IDLE = 3'b001,
    BFB_EMIT = 3'b010,
    BFB_DONE = 3'b100
  } bfb_state_t;

  // Byte with end-of-beacon marker
  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } bfb_byte_t;

  // Route cost update inputs
  typedef struct packed {
    logic       valid;
    logic [7:0] cost;
  } bfb_cost_t;
endpackage

// File: core/bfb_fifo.sv
// Parameterised valid/ready FIFO for the beacon byte stream
`timescale 1ns/1ns
module bfb_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  // Fill side
  input  wire logic             i_wr_valid,
  input  wire logic [WIDTH-1:0] i_wr_data,
  output logic                  o_wr_ready,
  // Drain side
  output logic                  o_rd_valid,
  output logic      [WIDTH-1:0] o_rd_data,
  input  wire logic             i_rd_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      cnt_r;
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [WIDTH-1:0] head_r;
  logic             head_vld_r;
  logic             wr_en;
  logic             take;
  logic             refill;
  logic             bypass;
  logic             mem_wr;
  logic             mem_rd;

  // Head word sits in a register so the drain side comes from flops
  assign o_wr_ready = ((cnt_r + (AW+1)'(head_vld_r)) != DEPTH[AW:0]);
  assign o_rd_valid = head_vld_r;
  assign o_rd_data  = head_r;
  assign wr_en      = i_wr_valid && o_wr_ready;
  assign take       = head_vld_r && i_rd_ready;
  assign refill     = !head_vld_r || take;
  assign mem_rd     = refill && (cnt_r != '0);
  assign bypass     = refill && (cnt_r == '0) && wr_en;
  assign mem_wr     = wr_en && !bypass;

  always_ff @(posedge i_sys_clk) begin
    if (mem_wr) begin
      mem[wp_r] <= i_wr_data;
    end
    if (i_rst) begin
      cnt_r      <= '0;
      wp_r       <= '0;
      rp_r       <= '0;
      head_r     <= '0;
      head_vld_r <= 1'b0;
    end else begin
      if (mem_wr) begin
        wp_r <= wp_r + 1'b1;
      end
      if (mem_rd) begin
        rp_r   <= rp_r + 1'b1;
        head_r <= mem[rp_r];
      end else if (bypass) begin
        head_r <= i_wr_data;
      end
      if (refill) begin
        head_vld_r <= mem_rd || bypass;
      end
      cnt_r <= cnt_r + (AW+1)'(mem_wr) - (AW+1)'(mem_rd);
    end
  end
endmodule

// File: sim/bfb_phy_model.sv
// PHY-side sink for the beacon byte stream and acknowledgement requests
`timescale 1ns/1ns
module bfb_phy_model
  import bfb_pkg::*;
(
  // Clock and reset
  input  wire logic      i_sys_clk,
  input  wire logic      i_rst,
  // Byte stream from the builder
  input  wire bfb_byte_t i_tx_byte,
  input  wire logic      i_tx_valid,
  output logic           o_tx_ready,
  // Acknowledgement request
  input  wire logic      i_ack,
  // Flow control from the bench
  input  wire logic      i_hold,
  input  wire logic      i_slow
);
  bfb_byte_t rx_q[$];
  int        ack_cnt = 0;
  logic      tog_r   = 1'b0;
  // ==========================================================
  // Slow mode takes a byte only every other cycle
  assign o_tx_ready = ~i_rst & ~i_hold & (~i_slow | tog_r);
  always @(posedge i_sys_clk) begin
    tog_r <= ~tog_r & ~i_rst;
    if (!i_rst && i_tx_valid && o_tx_ready) begin
      rx_q.push_back(i_tx_byte);
    end
    if (!i_rst && i_ack) begin
      ack_cnt++;
    end
  end
endmodule

// File: sim/beacon_frame_field_builder_bench.sv
// Self-checking bench for the beacon frame field builder
`timescale 1ns/1ns
module beacon_frame_field_builder_bench;
  import bfb_pkg::*;
  logic       i_sys_clk = 0, i_rst = 1, is_coord = 0, assoc = 0, fail = 0;
  logic       beacon_req = 0, ack_req = 0, hold = 0, slow = 0;
  logic       tx_valid, tx_ready, busy, ack;
  logic [7:0] cost, exp_cost = BFB_COST_MAX;
  bfb_cost_t  prp = '0, rrq = '0, rrp = '0;
  bfb_byte_t  tx_byte, exp_q[$];
  int         n_errors = 0, cmp_count = 0, cyc = 0, seed = 32'h73CE, i;

  always #20 i_sys_clk = ~i_sys_clk;

  bfb_builder i_dut (.i_sys_clk, .i_rst, .i_is_coord(is_coord), .i_assoc(assoc),
    .i_coord_fail(fail), .i_path_reply_packet(prp), .i_route_request_packet(rrq),
    .i_route_reply_packet(rrp), .i_beacon_req(beacon_req), .i_ack_req(ack_req),
    .o_tx_byte(tx_byte), .o_tx_valid(tx_valid), .i_tx_ready(tx_ready), .o_busy(busy),
    .o_coordinator_route_cost(cost), .o_phy_ack_send_primitive(ack));
  bfb_phy_model i_phy (.i_sys_clk, .i_rst, .i_tx_byte(tx_byte), .i_tx_valid(tx_valid),
    .o_tx_ready(tx_ready), .i_ack(ack), .i_hold(hold), .i_slow(slow));

  // ==========================================================
  // Checking and closing
  task automatic check(string what, logic [8:0] seen, logic [8:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // Expected cost: coordinator, then failure, then association, then minimum
  function automatic logic [7:0] next_cost(logic [7:0] c);
    logic [7:0] m;
    m = c;
    if (prp.valid && prp.cost < m) m = prp.cost;
    if (rrq.valid && rrq.cost < m) m = rrq.cost;
    if (rrp.valid && rrp.cost < m) m = rrp.cost;
    if (is_coord) return BFB_COST_COORD;
    if (fail) return BFB_COST_MAX;
    if (assoc) return BFB_COST_ASSOC;
    return m;
  endfunction
  function automatic bfb_cost_t rnd();
    return {1'($random(seed)), 8'($random(seed))};
  endfunction

  // ==========================================================
  // Stimulus tasks
  task automatic ev(logic c, logic f, logic a, bfb_cost_t p, bfb_cost_t q, bfb_cost_t r);
    @(posedge i_sys_clk);
    is_coord <= c;
    fail <= f;
    assoc <= a;
    prp <= p;
    rrq <= q;
    rrp <= r;
    #1 exp_cost = next_cost(exp_cost);
    @(posedge i_sys_clk);
    fail <= 0;
    assoc <= 0;
    prp <= '0;
    rrq <= '0;
    rrp <= '0;
    #1 check("route cost", {1'b0, cost}, {1'b0, exp_cost});
  endtask
  task automatic wait_idle();
    int k;
    for (k = 0; k < 80 && busy !== 1'b0; k++) begin
      @(posedge i_sys_clk);
      #1;
    end
    if (k == 80) check("idle wait", {8'h0, busy}, 9'h0);
  endtask
  task automatic req_beacon();
    wait_idle();
    @(posedge i_sys_clk);
    beacon_req <= 1;
    exp_q.push_back({1'b0, BFB_ORDER_ZERO, BFB_ORDER_ZERO});
    exp_q.push_back({1'b0, BFB_ASSOC_PERMIT, 2'b00, BFB_BATT_EXT, BFB_SLOT_ZERO});
    exp_q.push_back({1'b0, BFB_GTS_PERMIT, 4'h0, BFB_CNT_ZERO});
    exp_q.push_back({1'b0, 1'b0, BFB_CNT_ZERO, 1'b0, BFB_CNT_ZERO});
    exp_q.push_back({1'b1, exp_cost});
    @(posedge i_sys_clk);
    beacon_req <= 0;
    #1;
  endtask
  task automatic drain();
    int k;
    wait_idle();
    for (k = 0; k < 200 && i_phy.rx_q.size() < exp_q.size(); k++) @(posedge i_sys_clk);
    repeat (4) @(posedge i_sys_clk);
    check("byte count", 9'(i_phy.rx_q.size()), 9'(exp_q.size()));
    foreach (exp_q[j]) check("beacon byte", i_phy.rx_q[j], exp_q[j]);
    exp_q.delete();
    i_phy.rx_q.delete();
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_rst <= 0;
    #1 check("reset cost", {1'b0, cost}, {1'b0, BFB_COST_MAX});
    check("reset idle", {7'h0, busy, tx_valid}, 9'h0);
    ev(0, 0, 1, '0, '0, '0);
    req_beacon();
    req_beacon();
    drain();
    ev(0, 0, 0, {1'b1, 8'hFF}, {1'b1, 8'h01}, {1'b1, 8'h00});
    for (i = 0; i < 24; i++) begin
      ev(0, ($random(seed) & 7) == 0, ($random(seed) & 7) == 1, rnd(), rnd(), rnd());
      if (i % 6 == 5) req_beacon();
    end
    drain();
    ev(1, 1, 1, rnd(), rnd(), rnd());
    req_beacon();
    ev(0, 1, 1, '0, '0, '0);
    req_beacon();
    drain();
    @(posedge i_sys_clk);
    ack_req <= 1;
    @(posedge i_sys_clk);
    ack_req <= 0;
    #1 check("ack pulse", {8'h0, ack}, 9'h1);
    @(posedge i_sys_clk);
    #1 check("ack end", {8'h0, ack}, 9'h0);
    check("ack count", 9'(i_phy.ack_cnt), 9'h1);
    @(posedge i_sys_clk);
    slow <= 1;
    req_beacon();
    req_beacon();
    drain();
    @(posedge i_sys_clk);
    slow <= 0;
    hold <= 1;
    repeat (4) req_beacon();
    repeat (20) @(posedge i_sys_clk);
    #1 check("full stall", {7'h0, busy, tx_valid}, 9'h3);
    @(posedge i_sys_clk);
    hold <= 0;
    drain();
    tally_and_finish();
  end
endmodule
